/* tb/smm_host_model.sv */
// Command master model that frames words for the register slice
`timescale 1ns/10ps
`default_nettype none

module smm_host_model (
    input  wire logic          CORE_CLK,
    input  wire logic          parity_en,
    output logic               cmd_valid,
    output smm_pkg::smm_cmd_s  cmd
);
    import smm_pkg::*;
    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
    end
    task automatic send(input logic [1:0] ctrl, input logic [4:0] addr,
                        input logic [7:0] data, input logic bad);
        smm_cmd_s c;
        c = '{ctrl, addr, 1'b0, data};
        if (ctrl == CTRL_READ) c.parity = 1'b1;
        else if (parity_en) c.parity = ~(^{ctrl, addr, data}) ^ bad;
        @(posedge CORE_CLK) #1;
        cmd_valid = 1'b1;
        cmd = c;
        @(posedge CORE_CLK) #1;
        cmd_valid = 1'b0;
    endtask
endmodule // smm_host_model

`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the monitor and scratch register slice
`timescale 1ns/10ps
`default_nettype none

module tb;
    import smm_pkg::*;
    logic       CORE_CLK = 0, RSTN = 0, CE = 1, PARITY_EN = 1;
    logic       CAN_REG_ON = 1, NORMAL_MODE = 1;
    logic       CMD_VALID, RESP_VALID, PARITY_ERR, MON_RES_EN, MON_IO_ATTEN;
    smm_cmd_s   CMD;
    smm_resp_s  RESP;
    logic [2:0] MON_SRC_SEL;
    logic [7:0] d;
    int         n_errors = 0, compares = 0;

    always #5 CORE_CLK = ~CORE_CLK;

    smm_host_model i_host (.CORE_CLK(CORE_CLK), .parity_en(PARITY_EN),
        .cmd_valid(CMD_VALID), .cmd(CMD));
    smm_regs i_dut (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .CE(CE), .CMD_VALID(CMD_VALID),
        .CMD(CMD), .PARITY_EN(PARITY_EN), .CAN_REG_ON(CAN_REG_ON),
        .NORMAL_MODE(NORMAL_MODE), .RESP_VALID(RESP_VALID), .RESP(RESP),
        .PARITY_ERR(PARITY_ERR), .MON_SRC_SEL(MON_SRC_SEL), .MON_RES_EN(MON_RES_EN),
        .MON_IO_ATTEN(MON_IO_ATTEN));

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] v, input logic bad = 1'b0);
        i_host.send(CTRL_WRITE, a, v, bad);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] v, input logic ok = 1'b1);
        i_host.send(CTRL_READ, a, 8'h00, 1'b0);
        chk("resp_valid", {15'h0, ok}, {15'h0, RESP_VALID});
        if (ok) chk("resp", {STATUS_BYTE, v}, RESP);
    endtask
    task automatic wrap_up;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge CORE_CLK);
        n_errors++;
        wrap_up();
    end

    initial begin
        repeat (5) @(posedge CORE_CLK);
        #1 RSTN = 1;
        for (int a = 0; a < 5; a++) rd(5'(a), 8'h00);
        for (int a = 1; a < 5; a++) wr(5'(a), 8'(8'h11 * a));
        for (int a = 1; a < 5; a++) rd(5'(a), 8'(8'h11 * a));
        wr(5'h01, 8'h3c, 1'b1);
        chk("parity_err", 16'h1, {15'h0, PARITY_ERR});
        rd(5'h01, 8'h11);
        wr(5'h03, 8'h3c);
        chk("parity_ok", 16'h0, {15'h0, PARITY_ERR});
        rd(5'h03, 8'h3c);
        PARITY_EN = 0;
        wr(5'h02, 8'h5a);
        chk("parity_off", 16'h0, {15'h0, PARITY_ERR});
        rd(5'h02, 8'h5a);
        for (int i = 0; i < 8; i++) begin
            d = {i[2:0], i[0], ~i[0], 3'b111};
            wr(5'h00, d);
            chk("src", {13'h0, i[2:0]}, {13'h0, MON_SRC_SEL});
            chk("res", {15'h0, i[0]}, {15'h0, MON_RES_EN});
            chk("att", {15'h0, i == 4}, {15'h0, MON_IO_ATTEN});
            rd(5'h00, d & 8'hf8);
        end
        CE = 0;
        wr(5'h01, 8'hff);
        CE = 1;
        rd(5'h01, 8'h11);
        rd(5'h05, 8'h00, 1'b0);
        i_host.send(2'b10, 5'h01, 8'h77, 1'b0);
        rd(5'h01, 8'h11);
        i_host.send(CTRL_READ, 5'h01, 8'h80, 1'b0);
        chk("bad_read", 16'h0, {15'h0, RESP_VALID});
        CAN_REG_ON = 0;
        wr(5'h00, 8'he8);
        chk("src_off", 16'h0, {13'h0, MON_SRC_SEL});
        rd(5'h00, 8'h00, 1'b0);
        CAN_REG_ON = 1;
        wr(5'h00, 8'he0);
        chk("src_on", 16'h7, {13'h0, MON_SRC_SEL});
        NORMAL_MODE = 0;
        @(posedge CORE_CLK) #1;
        chk("src_mode", 16'h0, {13'h0, MON_SRC_SEL});
        wr(5'h00, 8'he0);
        rd(5'h00, 8'h00);
        NORMAL_MODE = 1;
        wr(5'h00, 8'h50);
        chk("res_on", 16'h1, {15'h0, MON_RES_EN});
        RSTN = 0;
        @(posedge CORE_CLK) #1;
        RSTN = 1;
        chk("res_rst", 16'h0, {15'h0, MON_RES_EN});
        rd(5'h04, 8'h00);
        wrap_up();
    end
endmodule // tb

`default_nettype wire

/* verilog/smm_cmd_decode.sv */
// Command frame decoder with optional parity check
`timescale 1ns/10ps
`default_nettype none

module smm_cmd_decode (
    input  wire smm_pkg::smm_cmd_s cmd,
    input  wire logic              parity_en,
    output logic                   is_write,
    output logic                   is_read,
    output logic                   parity_ok
);
    import smm_pkg::*;

    wire logic odd_total;

    // RULE3 odd parity total
    assign odd_total = ^{cmd.ctrl, cmd.addr, cmd.parity, cmd.data};

    // RULE1 parity optional
    assign parity_ok = !parity_en || odd_total;

    // RULE4 write frame code
    assign is_write = (cmd.ctrl == CTRL_WRITE);

    // RULE11 read-back frame
    assign is_read = (cmd.ctrl == CTRL_READ) && cmd.parity && !cmd.data[READ_SUB_BIT];

endmodule // smm_cmd_decode

`default_nettype wire

/* verilog/smm_pkg.sv */
// Shared types and constants for the monitor/scratch register slice
package smm_pkg;

    // Command control codes in bits 15-14
    localparam logic [1:0] CTRL_READ  = 2'b00;
    localparam logic [1:0] CTRL_WRITE = 2'b01;

    // Register addresses in bits 13-9
    localparam logic [4:0] ADDR_MONITOR   = 5'h00;
    localparam logic [4:0] ADDR_SCRATCH_A = 5'h01;
    localparam logic [4:0] ADDR_SCRATCH_D = 5'h04;
    localparam int         SCRATCH_COUNT  = 4;

    // Monitor control register fields
    localparam int SRC_SEL_MSB  = 7;
    localparam int SRC_SEL_LSB  = 5;
    localparam int RES_EN_BIT   = 4;
    localparam int IO_ATTEN_BIT = 3;
    localparam int RSV_MSB      = 2;

    // Read-back request: bit 7 of the payload must be clear
    localparam int READ_SUB_BIT = 7;

    // Monitor source codes
    localparam logic [2:0] SRC_OFF       = 3'h0;
    localparam logic [2:0] SRC_REG_CUR   = 3'h1;
    localparam logic [2:0] SRC_VREF      = 3'h2;
    localparam logic [2:0] SRC_TEMP      = 3'h3;
    localparam logic [2:0] SRC_IO0       = 3'h4;
    localparam logic [2:0] SRC_IO1       = 3'h5;
    localparam logic [2:0] SRC_SUPPLY    = 3'h6;
    localparam logic [2:0] SRC_SENSE_PIN = 3'h7;

    // Values after reset
    localparam logic [7:0] MONITOR_RESET = 8'h00;
    localparam logic [7:0] SCRATCH_RESET = 8'h00;
    localparam logic [7:0] STATUS_BYTE   = 8'h00;

    typedef struct packed {
        logic [1:0] ctrl;
        logic [4:0] addr;
        logic       parity;
        logic [7:0] data;
    } smm_cmd_s;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] data;
    } smm_resp_s;

endpackage

/* verilog/smm_regs.sv */
// Monitor control and scratch register slice reached by command frames
// How it works
// RULE1 - Parity checking of commands is on only when the enable input is high.
// RULE2 - With parity checking off, the master sends bit 8 as zero.
// RULE3 - Write parity makes ones in bits 15-9, 7-0 plus bit 8 odd.
// RULE4 - Write frame: code 01, address 13-9, parity 8, data 7-0.
// RULE5 - Monitor register top three bits choose the monitor source; 000 turns it off.
// RULE6 - Monitor bit 4 connects the internal sense resistor to the monitor node.
// RULE7 - Monitor bit 3 picks attenuation, used only for sources 100 and 101.
// RULE8 - Monitor register clears on reset, supply regulator off, or outside Normal.
// RULE9 - With supply regulator off, monitor accesses are ignored and bits forced zero.
// RULE10 - Four byte scratch registers at addresses 1 to 4, zero after reset.
// RULE11 - Read-back uses code 00, bit 8 set, bit 7 clear; data returns low.
// RULE12 - Monitor bits 2 to 0 always read as zero.
`timescale 1ns/10ps
`default_nettype none

module smm_regs #(
    parameter int DATA_W = 8
) (
    input  wire  logic              CORE_CLK,
    input  wire  logic              RSTN,
    input  wire  logic              CE,
    input  wire  logic              CMD_VALID,
    input  wire  smm_pkg::smm_cmd_s CMD,
    input  wire  logic              PARITY_EN,
    input  wire  logic              CAN_REG_ON,
    input  wire  logic              NORMAL_MODE,
    output logic                    RESP_VALID,
    output smm_pkg::smm_resp_s      RESP,
    output logic                    PARITY_ERR,
    output logic [2:0]              MON_SRC_SEL,
    output logic                    MON_RES_EN,
    output logic                    MON_IO_ATTEN
);
    import smm_pkg::*;

    logic [DATA_W-1:0] mon_reg;
    logic [DATA_W-1:0] mon_next;
    logic [DATA_W-1:0] scratch_reg [SCRATCH_COUNT];
    logic              io_att_reg;
    logic              io_att_next;
    logic              resp_valid_reg;
    smm_resp_s         resp_reg;
    logic              par_err_reg;

    wire logic              is_write;
    wire logic              is_read;
    wire logic              parity_ok;
    wire logic              take;
    wire logic              wr_ok;
    wire logic              mon_hit;
    wire logic              scr_hit;
    wire logic [1:0]        scr_idx;
    wire logic              mon_allowed;
    wire logic              mon_wr;
    wire logic              rd_ok;
    wire logic [DATA_W-1:0] rd_data;
    wire logic [2:0]        next_src;

    smm_cmd_decode u_dec (
        .cmd       (CMD),
        .parity_en (PARITY_EN),
        .is_write  (is_write),
        .is_read   (is_read),
        .parity_ok (parity_ok)
    );

    assign take    = CE && CMD_VALID;
    assign wr_ok   = take && is_write && parity_ok;
    assign mon_hit = (CMD.addr == ADDR_MONITOR);
    assign scr_hit = (CMD.addr >= ADDR_SCRATCH_A) && (CMD.addr <= ADDR_SCRATCH_D);
    assign scr_idx = 2'(CMD.addr - ADDR_SCRATCH_A);

    // RULE8 clear outside Normal
    assign mon_allowed = CAN_REG_ON && NORMAL_MODE;
    assign mon_wr      = wr_ok && mon_hit;

    // RULE9 forced zero when off
    // RULE12 reserved bits stored zero
    assign mon_next = !mon_allowed ? MONITOR_RESET :
                      mon_wr ? {CMD.data[DATA_W-1:RSV_MSB+1], (RSV_MSB+1)'(0)} : mon_reg;

    // RULE7 attenuation only for I/O sources
    assign next_src    = mon_next[SRC_SEL_MSB:SRC_SEL_LSB];
    assign io_att_next = mon_next[IO_ATTEN_BIT] && (next_src == SRC_IO0 || next_src == SRC_IO1);

    // RULE9 monitor read ignored when off
    assign rd_ok   = take && is_read && ((mon_hit && CAN_REG_ON) || scr_hit);
    assign rd_data = mon_hit ? mon_reg : scratch_reg[scr_idx];

    // RULE5 monitor register update
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            mon_reg    <= MONITOR_RESET;
            io_att_reg <= 1'b0;
        end else if (CE) begin
            mon_reg    <= mon_next;
            io_att_reg <= io_att_next;
        end
    end

    // RULE10 scratch storage
    for (genvar i = 0; i < SCRATCH_COUNT; i++) begin : g_scr
        always_ff @(posedge CORE_CLK or negedge RSTN) begin
            if (!RSTN) begin
                scratch_reg[i] <= SCRATCH_RESET;
            end else if (wr_ok && scr_hit && scr_idx == 2'(i)) begin
                scratch_reg[i] <= CMD.data;
            end
        end
    end

    // RULE11 read-back answer
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            resp_valid_reg <= 1'b0;
            resp_reg       <= '0;
            par_err_reg    <= 1'b0;
        end else if (CE) begin
            resp_valid_reg <= rd_ok;
            if (rd_ok) begin
                resp_reg <= '{status: STATUS_BYTE, data: rd_data};
            end
            // RULE3 bad parity flagged
            par_err_reg <= take && is_write && !parity_ok;
        end
    end

    assign RESP_VALID   = resp_valid_reg;
    assign RESP         = resp_reg;
    assign PARITY_ERR   = par_err_reg;
    assign MON_SRC_SEL  = mon_reg[SRC_SEL_MSB:SRC_SEL_LSB];
    // RULE6 internal resistor enable
    assign MON_RES_EN   = mon_reg[RES_EN_BIT];
    assign MON_IO_ATTEN = io_att_reg;

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RSTN);

    mon_clear_a: assert property ( // RULE8
        CE && !NORMAL_MODE |=> MON_SRC_SEL == SRC_OFF && !MON_RES_EN)
        else $error("Monitor register not cleared outside Normal");

    can_off_ign_a: assert property ( // RULE9
        CE && CMD_VALID && !CAN_REG_ON && mon_hit && is_read |=> !RESP_VALID)
        else $error("Monitor read answered while regulator off");

    can_off_zero_a: assert property (CE && !CAN_REG_ON |=> mon_reg == MONITOR_RESET) // RULE9
        else $error("Monitor bits not forced zero while regulator off");

    mon_write_a: assert property ( // RULE5
        mon_wr && mon_allowed |=> MON_SRC_SEL == $past(CMD.data[SRC_SEL_MSB:SRC_SEL_LSB]))
        else $error("Monitor source not taken from write");

    res_en_a: assert property ( // RULE6
        mon_wr && mon_allowed |=> MON_RES_EN == $past(CMD.data[RES_EN_BIT]))
        else $error("Resistor enable not taken from write");

    io_att_a: assert property ( // RULE7
        MON_IO_ATTEN |-> (MON_SRC_SEL == SRC_IO0 || MON_SRC_SEL == SRC_IO1))
        else $error("Attenuation active for non I/O source");

    io_gain_a: assert property ( // RULE7
        mon_wr && mon_allowed && !CMD.data[IO_ATTEN_BIT] |=> !MON_IO_ATTEN)
        else $error("Attenuation set although gain was written");

    io_att_set_a: assert property ( // RULE7
        mon_wr && mon_allowed && CMD.data[IO_ATTEN_BIT]
        && (next_src == SRC_IO0 || next_src == SRC_IO1) |=> MON_IO_ATTEN)
        else $error("Attenuation not set for I/O source");

    rsv_zero_a: assert property (mon_reg[RSV_MSB:0] == '0) // RULE12
        else $error("Reserved monitor bits not zero");

    scratch_wr_a: assert property ( // RULE10
        wr_ok && CMD.addr == ADDR_SCRATCH_A |=> scratch_reg[0] == $past(CMD.data))
        else $error("Scratch byte not stored");

    scr_last_a: assert property ( // RULE10
        wr_ok && CMD.addr == ADDR_SCRATCH_D
        |=> scratch_reg[SCRATCH_COUNT-1] == $past(CMD.data) && $stable(scratch_reg[0]))
        else $error("Last scratch byte not stored alone");

    read_back_a: assert property ( // RULE11
        take && is_read && scr_hit |=> RESP_VALID && RESP.data == $past(rd_data))
        else $error("Read-back data wrong or missing");

    mon_read_a: assert property ( // RULE11
        take && is_read && mon_hit && CAN_REG_ON |=> RESP_VALID && RESP.data == $past(mon_reg))
        else $error("Monitor read-back wrong or missing");

    bad_read_a: assert property ( // RULE11
        take && CMD.ctrl == CTRL_READ && (!CMD.parity || CMD.data[READ_SUB_BIT])
        |=> !RESP_VALID)
        else $error("Malformed read answered");

    resp_status_a: assert property (RESP_VALID |-> RESP.status == STATUS_BYTE) // RULE11
        else $error("Response status byte wrong");

    parity_chk_a: assert property ( // RULE3
        take && is_write && PARITY_EN && !(^CMD) |=> PARITY_ERR)
        else $error("Even parity write not flagged");

    par_ok_a: assert property ( // RULE3
        take && is_write && PARITY_EN && (^CMD) |=> !PARITY_ERR)
        else $error("Odd parity write flagged");

    par_drop_a: assert property ( // RULE3
        take && is_write && PARITY_EN && !(^CMD)
        |=> $stable(scratch_reg[0]) && $stable(scratch_reg[1])
            && $stable(scratch_reg[2]) && $stable(scratch_reg[3]))
        else $error("Bad parity write changed scratch");

    parity_off_a: assert property (take && is_write && !PARITY_EN |=> !PARITY_ERR) // RULE1
        else $error("Parity error with checking disabled");

    frame_fmt_a: assert property ( // RULE4
        take && CMD.ctrl != CTRL_WRITE |=> $stable(scratch_reg[0]) && $stable(scratch_reg[3]))
        else $error("Non write frame changed scratch");

    write_quiet_a: assert property (take && is_write |=> !RESP_VALID) // RULE4
        else $error("Write frame answered with response");

    mon_wr_c: cover property (mon_wr && mon_allowed ##1 MON_SRC_SEL != SRC_OFF);
    io_att_c: cover property (MON_IO_ATTEN);
    scr_rd_c: cover property (wr_ok && scr_hit ##[1:4] RESP_VALID);
    par_err_c: cover property (PARITY_ERR);
    mon_rd_c: cover property (take && is_read && mon_hit ##1 RESP_VALID);

endmodule // smm_regs

`default_nettype wire
